// file: design/kto_map.svh
// offsets, reset values and timing counts of the keypad menu controller
`ifndef KTO_MAP_SVH
`define KTO_MAP_SVH
`define KTO_CLK_HZ 10000000
`define KTO_TICK_MS 1
`define KTO_TICK_CYC (`KTO_CLK_HZ / 1000 * `KTO_TICK_MS)
`define KTO_LONG_MS 2000
`define KTO_BLINK_MS 2000
`define KTO_ON_LONG_MS 1900
`define KTO_ON_SHORT_MS 100
`define KTO_ERASE_ON_MS 1000
`define KTO_HBLINK_MS 150
`define KTO_HOLD2_MS 10
`define KTO_HOLD3_MS 1000
`define KTO_CTRL_OFS 12'h000
`define KTO_STATUS_OFS 12'h004
`define KTO_TOL_OFS 12'h008
`define KTO_NOMATCH_RST 8'hff
`define KTO_TOL_RST 3'h3
`define KTO_HOLD_RST 2'h1
`define KTO_SPH1 8'h03
`define KTO_SPH2 8'h05
`define KTO_SPH3 8'h0a
`define KTO_SPH4 8'h14
`define KTO_SPH5 8'h28
`define KTO_SPH6 8'h3c
`define KTO_SPH7 8'h50
`define KTO_SPH8 8'h78
`endif

// file: design/kto_menu.sv
// keypad teach, tolerance and options menu controller with apb status access
`timescale 1ns/1ps
`include "kto_map.svh"
module kto_menu import kto_pkg::*; #(
    parameter int TICK_CYC = `KTO_TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire kto_keys_t keys,
    input wire logic switching_input_zero,
    input wire logic match_valid,
    input wire logic [2:0] match_group,
    output logic [7:0] out_led,
    output logic [7:0] sphere_limit,
    output logic commit_pulse,
    output logic discard_pulse,
    output logic erase_pulse,
    output logic teach_req,
    output logic [2:0] teach_group,
    output kto_cfg_t cfg_active,
    output logic [23:0] tol_stages
);
    localparam kto_cfg_t CFG_RST = '{role: KTO_ROLE_NONE, hold: `KTO_HOLD_RST, multi: 1'b0, prof: 2'h0};
    localparam kto_regs_t RST = '{st: KTO_RUN, nomatch: `KTO_NOMATCH_RST, margin_key: {8{`KTO_TOL_RST}},
        tol_sh: {8{`KTO_TOL_RST}}, cfg: CFG_RST, cfg_sh: CFG_RST, default: '0};

    kto_regs_t q;
    kto_regs_t n;
    kto_keys_t sh_ev;
    kto_keys_t lg_ev;
    logic [2:0] stage_w;
    logic sw_rise;
    logic [7:0] live;

    // sphere limit in tenths of delta e for a stage code 0..7
    function automatic logic [7:0] sphere_of(input logic [2:0] s);
        case (s)
            3'h0: sphere_of = `KTO_SPH1;
            3'h1: sphere_of = `KTO_SPH2;
            3'h2: sphere_of = `KTO_SPH3;
            3'h3: sphere_of = `KTO_SPH4;
            3'h4: sphere_of = `KTO_SPH5;
            3'h5: sphere_of = `KTO_SPH6;
            3'h6: sphere_of = `KTO_SPH7;
            default: sphere_of = `KTO_SPH8;
        endcase
    endfunction

    // on/off blink of an option indicator
    function automatic logic on_pat(input logic on, input logic [10:0] ph);
        on_pat = on ? (ph < 11'(`KTO_ON_LONG_MS)) : (ph < 11'(`KTO_ON_SHORT_MS));
    endfunction

    // hold time in ms per stage
    function automatic logic [10:0] hold_ms(input logic [1:0] h);
        case (h)
            2'h2: hold_ms = 11'(`KTO_HOLD2_MS);
            2'h3: hold_ms = 11'(`KTO_HOLD3_MS);
            default: hold_ms = 11'h000;
        endcase
    endfunction

    // helper views of the current state
    assign stage_w = q.tol_sh[q.sel * 3 +: 3];
    assign sw_rise = q.sw_s2 && !q.sw_prev;
    assign live = match_valid ? (8'h01 << match_group) : q.nomatch;

    // next-state logic of the whole block
    always_comb begin
        n = q;
        sh_ev = '0;
        lg_ev = '0;
        n.key_s1 = keys;
        n.key_s2 = q.key_s1;
        n.sw_s1 = switching_input_zero;
        n.sw_s2 = q.sw_s1;
        n.sw_prev = q.sw_s2;
        n.commit = 1'b0;
        n.discard = 1'b0;
        n.erase = 1'b0;
        // millisecond enable
        n.tick = (q.tick_cnt == 14'(TICK_CYC - 1));
        n.tick_cnt = n.tick ? 14'h0000 : q.tick_cnt + 14'h0001;
        if (q.tick) begin
            n.deb = q.key_s2; // keys sampled once per ms
            n.ph = (q.ph == 11'(`KTO_BLINK_MS - 1)) ? 11'h000 : q.ph + 11'h001;
            if (q.hsub == 8'(`KTO_HBLINK_MS - 1)) begin
                n.hsub = 8'h00;
                n.hslot = q.hslot + 3'h1; // eight 150 ms slots make 1200 ms
            end else begin
                n.hsub = q.hsub + 8'h01;
            end
            // one key timed at a time
            if (q.act) begin
                if (!q.deb[q.act_key]) begin
                    n.act = 1'b0;
                    sh_ev[q.act_key] = !q.long_done; // release before 2 s is short
                end else if (!q.long_done) begin
                    n.press = q.press + 11'h001;
                    if (q.press == 11'(`KTO_LONG_MS - 1)) begin
                        lg_ev[q.act_key] = 1'b1; // long fires while still held
                        n.long_done = 1'b1;
                    end
                end
            end else if (q.deb != 8'h00) begin
                n.act = 1'b1;
                n.press = 11'h000;
                n.long_done = 1'b0;
                for (int i = 7; i >= 0; i--) begin
                    if (q.deb[i]) begin
                        n.act_key = 3'(i);
                    end
                end
            end
        end
        // result shown on the switching outputs
        if (q.cfg.role == KTO_ROLE_GATE) begin
            if (sw_rise) begin
                n.res = live; // evaluate only on rising edge
            end
        end else if (match_valid) begin
            n.res = live; // detected group
            n.hold_cnt = hold_ms(q.cfg.hold); // one hold for all outputs
        end else if (q.hold_cnt != 11'h000) begin
            if (q.tick) begin
                n.hold_cnt = q.hold_cnt - 11'h001;
            end
        end else begin
            n.res = q.nomatch; // no-match pattern
        end
        // menu sequencing
        case (q.st)
            KTO_RUN: begin
                if (lg_ev.learn) begin
                    n.st = KTO_TEACH;
                    n.sel = 3'h0;
                    n.tol_sh = q.margin_key;
                end else if (lg_ev.clear) begin
                    n.st = KTO_ERASE;
                end else if (lg_ev.settings) begin
                    n.st = KTO_OPTS; // opens on the live configuration
                    n.cfg_sh = q.cfg;
                    n.ogrp = 2'h0;
                end
            end
            KTO_TEACH: begin
                if (sh_ev.right) begin
                    n.sel = q.sel + 3'h1;
                end else if (sh_ev.left) begin
                    n.sel = q.sel - 3'h1;
                end else if (sh_ev.margin) begin
                    n.st = KTO_TOL;
                end else if (lg_ev.confirm) begin
                    n.margin_key = q.tol_sh;
                    n.commit = 1'b1;
                    n.st = KTO_RUN;
                end else if (lg_ev.cancel) begin
                    n.discard = 1'b1;
                    n.st = KTO_RUN;
                end
            end
            KTO_TOL: begin
                if (sh_ev.right && stage_w != 3'h7) begin
                    n.tol_sh[q.sel * 3 +: 3] = stage_w + 3'h1; // per-group stage
                end else if (sh_ev.left && stage_w != 3'h0) begin
                    n.tol_sh[q.sel * 3 +: 3] = stage_w - 3'h1;
                end else if (sh_ev.learn) begin
                    n.st = KTO_TEACH;
                end
            end
            KTO_ERASE: begin
                if (lg_ev.confirm) begin
                    n.erase = 1'b1;
                    n.res = q.nomatch;
                    n.st = KTO_RUN;
                end else if (lg_ev.cancel) begin
                    n.st = KTO_RUN; // display follows detection again
                end
            end
            KTO_OPTS: begin
                if (sh_ev.right) begin
                    n.ogrp = q.ogrp + 2'h1;
                end else if (sh_ev.left) begin
                    n.ogrp = q.ogrp - 2'h1;
                end else if (sh_ev.learn) begin
                    // step the selected group
                    case (q.ogrp)
                        2'h0: begin
                            case (q.cfg_sh.role)
                                KTO_ROLE_NONE: n.cfg_sh.role = KTO_ROLE_GATE;
                                KTO_ROLE_GATE: n.cfg_sh.role = KTO_ROLE_TEACH;
                                default: n.cfg_sh.role = KTO_ROLE_NONE;
                            endcase
                        end
                        2'h1: n.cfg_sh.hold = (q.cfg_sh.hold == 2'h3) ? 2'h1 : q.cfg_sh.hold + 2'h1;
                        2'h2: n.cfg_sh.multi = !q.cfg_sh.multi;
                        default: n.cfg_sh.prof = q.cfg_sh.prof + 2'h1;
                    endcase
                end else if (lg_ev.confirm) begin
                    n.cfg = q.cfg_sh;
                    n.st = KTO_RUN;
                end else if (lg_ev.cancel) begin
                    n.st = KTO_RUN; // shadow dropped
                end
            end
            default: n.st = KTO_RUN;
        endcase
        // led display
        case (q.st)
            KTO_TEACH: n.led = 8'h01 << q.sel;
            KTO_TOL: n.led = 8'h01 << stage_w;
            KTO_ERASE: n.led = {8{q.ph < 11'(`KTO_ERASE_ON_MS)}};
            KTO_OPTS: begin
                n.led = 8'h00;
                case (q.ogrp)
                    2'h0: begin
                        n.led[0] = on_pat(q.cfg_sh.role == KTO_ROLE_GATE, q.ph);
                        n.led[1] = on_pat(q.cfg_sh.role == KTO_ROLE_TEACH, q.ph);
                    end
                    2'h1: n.led[2] = !q.hslot[0] && (q.hslot[2:1] < q.cfg_sh.hold);
                    2'h2: n.led[3] = on_pat(q.cfg_sh.multi, q.ph);
                    default: begin
                        for (int k = 0; k < 4; k++) begin
                            n.led[4 + k] = on_pat(q.cfg_sh.prof == 2'(k), q.ph);
                        end
                    end
                endcase
            end
            default: n.led = q.res;
        endcase
        // level teach request and tolerance limit
        n.teach_req = (q.st == KTO_RUN) && (q.cfg.role == KTO_ROLE_TEACH) && q.sw_s2;
        n.limit = sphere_of(q.margin_key[match_group * 3 +: 3]);
        // apb slave: answer set up in setup phase, zero wait access
        n.ready = 1'b0;
        n.slverr = 1'b0;
        if (psel && !penable && !q.ready) begin
            n.ready = 1'b1;
            case (paddr)
                `KTO_CTRL_OFS: n.rdata = {24'h000000, q.nomatch};
                `KTO_STATUS_OFS: n.rdata = {15'h0000, q.cfg, q.ogrp, q.sel, q.st};
                `KTO_TOL_OFS: n.rdata = {8'h00, q.margin_key};
                default: begin
                    n.rdata = 32'h00000000;
                    n.slverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && q.ready && pwrite && paddr == `KTO_CTRL_OFS) begin
            n.nomatch = pwdata[7:0];
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= RST;
        end else begin
            q <= n;
        end
    end

    // outputs straight from flops
    assign prdata = q.rdata;
    assign pready = q.ready;
    assign pslverr = q.slverr;
    assign out_led = q.led;
    assign sphere_limit = q.limit;
    assign commit_pulse = q.commit;
    assign discard_pulse = q.discard;
    assign erase_pulse = q.erase;
    assign teach_req = q.teach_req;
    assign teach_group = q.sel;
    assign cfg_active = q.cfg;
    assign tol_stages = q.margin_key;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    commit_exit_a: assert property (q.commit |-> q.st == KTO_RUN && $past(q.st) == KTO_TEACH && q.margin_key == $past(q.tol_sh))
        else $error("commit did not store edits or leave teach");
    discard_keep_a: assert property (q.discard |-> q.st == KTO_RUN && $stable(q.margin_key))
        else $error("cancel changed the tolerance table");
    erase_flash_a: assert property ((q.st == KTO_ERASE) ##1 (q.st == KTO_ERASE) |-> q.led == 8'hff || q.led == 8'h00)
        else $error("erase display not flashing all leds");
    erase_done_a: assert property (q.erase |=> q.led == $past(q.nomatch))
        else $error("erase did not show no-match pattern");
    tol_raise_a: assert property (q.st == KTO_TOL && sh_ev.right && stage_w != 3'h7 |=> stage_w == $past(stage_w) + 3'h1)
        else $error("tolerance stage not raised");
    cfg_shadow_a: assert property (q.st == KTO_OPTS |=> $stable(q.cfg) || q.st == KTO_RUN)
        else $error("active config changed inside options menu");
    gate_hold_a: assert property (q.st == KTO_RUN && q.cfg.role == KTO_ROLE_GATE && !sw_rise |=> $stable(q.res))
        else $error("gated output changed without trigger edge");
    opt_open_a: assert property (q.st == KTO_RUN && lg_ev.settings |=> q.st == KTO_OPTS && q.cfg_sh == $past(q.cfg))
        else $error("options menu not opened with live config");
    teach_level_a: assert property (q.teach_req |-> $past(q.sw_s2) && $past(q.cfg.role) == KTO_ROLE_TEACH)
        else $error("teach request without high input");
    short_press_a: assert property (sh_ev != 8'h00 |-> q.tick && q.act && !q.long_done && q.press < 11'(`KTO_LONG_MS))
        else $error("short press reported after long threshold");
endmodule

// file: design/kto_pkg.sv
// types of the keypad menu controller
package kto_pkg;
    typedef enum logic [4:0] {
        KTO_RUN = 5'b00001,
        KTO_TEACH = 5'b00010,
        KTO_TOL = 5'b00100,
        KTO_ERASE = 5'b01000,
        KTO_OPTS = 5'b10000
    } kto_state_t;
    typedef enum logic [1:0] {
        KTO_ROLE_NONE = 2'h0,
        KTO_ROLE_GATE = 2'h1,
        KTO_ROLE_TEACH = 2'h2
    } kto_role_t;
    typedef struct packed {
        logic right;
        logic left;
        logic settings;
        logic margin;
        logic clear;
        logic cancel;
        logic confirm;
        logic learn;
    } kto_keys_t;
    typedef struct packed {
        kto_role_t role;
        logic [1:0] hold;
        logic multi;
        logic [1:0] prof;
    } kto_cfg_t;
    typedef struct packed {
        kto_state_t st;
        logic [7:0] key_s1;
        logic [7:0] key_s2;
        logic [7:0] deb;
        logic sw_s1;
        logic sw_s2;
        logic sw_prev;
        logic [13:0] tick_cnt;
        logic tick;
        logic act;
        logic [2:0] act_key;
        logic [10:0] press;
        logic long_done;
        logic [2:0] sel;
        logic [1:0] ogrp;
        kto_cfg_t cfg;
        kto_cfg_t cfg_sh;
        logic [23:0] margin_key;
        logic [23:0] tol_sh;
        logic [10:0] ph;
        logic [10:0] hold_cnt;
        logic [7:0] hsub;
        logic [2:0] hslot;
        logic [7:0] res;
        logic [7:0] nomatch;
        logic [7:0] led;
        logic [7:0] limit;
        logic commit;
        logic discard;
        logic erase;
        logic teach_req;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } kto_regs_t;
endpackage

// file: testbench/kto_menu_tb.sv
// self-checking bench of the keypad menu controller
`timescale 1ns/1ps
module kto_menu_tb import kto_pkg::*;;
    localparam int TICK = 2;
    localparam int LONG = 2010;
    localparam int SHORT = 6;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic match_valid = 1'b0;
    logic [2:0] match_group = 3'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sw, commit_pulse, discard_pulse, erase_pulse, teach_req;
    logic [7:0] out_led, sphere_limit;
    logic [2:0] teach_group;
    kto_keys_t keys;
    kto_cfg_t cfg_active;
    logic [23:0] tol_stages;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    int n_commit = 0;
    int n_discard = 0;
    int n_erase = 0;
    logic [31:0] rd;
    logic err;

    kto_menu #(.TICK_CYC(TICK)) u_kto_menu (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .keys(keys), .switching_input_zero(sw), .match_valid(match_valid), .match_group(match_group),
        .out_led(out_led), .sphere_limit(sphere_limit), .commit_pulse(commit_pulse),
        .discard_pulse(discard_pulse), .erase_pulse(erase_pulse), .teach_req(teach_req),
        .teach_group(teach_group), .cfg_active(cfg_active), .tol_stages(tol_stages));
    kto_panel #(.TICK_CYC(TICK)) u_kto_panel (.pclk(pclk), .keys(keys), .sw(sw), .out_led(out_led));

    // clock
    always #50 pclk = ~pclk;

    // pulse counters and hang guard
    always @(posedge pclk) begin
        cyc++;
        n_commit += (commit_pulse === 1'b1);
        n_discard += (discard_pulse === 1'b1);
        n_erase += (erase_pulse === 1'b1);
        if (cyc == 90000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer, waiting for pready with no bound of its own
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // wait for the answer; only the bench timeout ends a hang
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic state_is(input logic [4:0] exp);
        apb(1'b0, 12'h004, 32'h0);
        check({27'h0, rd[4:0]}, {27'h0, exp}, "menu state");
    endtask

    // count cycles an led bit is lit over a window
    task automatic lit_count(input int bitn, input int cycles, output int n);
        n = 0;
        repeat (cycles) begin
            @(posedge pclk);
            n += (out_led[bitn] === 1'b1);
        end
    endtask

    task automatic t_reset();
        check(32'(cfg_active), 32'h08, "reset options");
        check(32'(tol_stages), 32'h6db6db, "reset stages");
        state_is(5'h01);
        apb(1'b0, 12'h00c, 32'h0);
        check({rd[30:0], err}, 32'h1, "unmapped read");
        $display("reset test done");
    endtask

    task automatic t_display();
        apb(1'b1, 12'h000, 32'h5a);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h5a, "pattern readback");
        check(32'(out_led), 32'h5a, "no-match leds");
        match_group <= 3'h2;
        match_valid <= 1'b1;
        repeat (10) @(posedge pclk);
        check(32'(out_led), 32'h04, "group leds");
        check(32'(sphere_limit), 32'h14, "sphere limit");
        match_valid <= 1'b0;
        repeat (10) @(posedge pclk);
        check(32'(out_led), 32'h5a, "no hold at stage 1");
        $display("display test done");
    endtask

    task automatic t_tolerance();
        int c0;
        u_kto_panel.press(0, LONG);
        state_is(5'h02);
        u_kto_panel.press(7, SHORT);
        check(32'(teach_group), 32'h1, "group select");
        u_kto_panel.press(4, SHORT);
        state_is(5'h04);
        check(32'(out_led), 32'h08, "stage shown");
        u_kto_panel.press(7, SHORT);
        u_kto_panel.press(7, SHORT);
        check(32'(out_led), 32'h20, "stage raised");
        u_kto_panel.press(6, SHORT);
        check(32'(out_led), 32'h10, "stage lowered");
        check(32'(tol_stages), 32'h6db6db, "stages before commit");
        u_kto_panel.press(0, SHORT);
        state_is(5'h02);
        c0 = n_commit;
        u_kto_panel.press(1, LONG);
        state_is(5'h01);
        check(n_commit - c0, 1, "commit pulses");
        check(32'(tol_stages), 32'h6db6e3, "committed stage");
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h006db6e3, "stage register");
        check(32'(out_led), 32'h5a, "display after commit");
        $display("tolerance test done");
    endtask

    task automatic t_discard();
        int d0;
        d0 = n_discard;
        u_kto_panel.press(0, LONG);
        u_kto_panel.press(4, SHORT);
        u_kto_panel.press(7, SHORT);
        u_kto_panel.press(0, SHORT);
        u_kto_panel.press(2, LONG);
        state_is(5'h01);
        check(n_discard - d0, 1, "discard pulses");
        check(32'(tol_stages), 32'h6db6e3, "stages kept");
        $display("discard test done");
    endtask

    task automatic t_erase();
        int e0;
        int on_n;
        e0 = n_erase;
        u_kto_panel.press(3, LONG);
        state_is(5'h08);
        fork
            u_kto_panel.press(2, LONG);
            lit_count(7, 3800, on_n);
        join
        check(32'(on_n > 1000 && on_n < 2800), 32'h1, "erase flash");
        state_is(5'h01);
        check(n_erase - e0, 0, "no erase on cancel");
        check(32'(out_led), 32'h5a, "display restored");
        u_kto_panel.press(3, LONG);
        u_kto_panel.press(1, LONG);
        check(n_erase - e0, 1, "erase pulses");
        check(32'(out_led), 32'h5a, "no-match after erase");
        $display("erase test done");
    endtask

    task automatic t_options();
        int on_n;
        u_kto_panel.press(5, LONG);
        state_is(5'h10);
        u_kto_panel.press(7, SHORT);
        apb(1'b0, 12'h004, 32'h0);
        check(32'(rd[9:8]), 32'h1, "next group");
        u_kto_panel.press(6, SHORT);
        lit_count(0, 3800, on_n);
        check(32'(on_n < 400), 32'h1, "off blink");
        u_kto_panel.press(0, SHORT);
        check(32'(cfg_active), 32'h08, "shadow only");
        fork
            u_kto_panel.press(1, LONG);
            lit_count(0, 3800, on_n);
        join
        check(32'(on_n > 3400), 32'h1, "on blink");
        check(32'(cfg_active), 32'h28, "gate role active");
        $display("options test done");
    endtask

    task automatic t_gate();
        match_group <= 3'h3;
        match_valid <= 1'b1;
        repeat (20) @(posedge pclk);
        check(32'(out_led), 32'h5a, "held without edge");
        u_kto_panel.pulse_input(10);
        check(32'(out_led), 32'h08, "updated on edge");
        check(32'(teach_req), 32'h0, "no teach request");
        $display("gate test done");
    endtask

    // teach role, hold stage 2 display and hold extension
    task automatic t_teach_role();
        int on_n;
        match_valid <= 1'b0;
        u_kto_panel.press(5, LONG);
        u_kto_panel.press(0, SHORT);
        u_kto_panel.press(7, SHORT);
        u_kto_panel.press(0, SHORT);
        lit_count(2, 2400, on_n);
        check(on_n, 600, "two hold blinks per cycle");
        u_kto_panel.press(1, LONG);
        check(32'(cfg_active), 32'h50, "teach role and hold 2");
        match_valid <= 1'b1;
        repeat (5) @(posedge pclk);
        match_valid <= 1'b0;
        repeat (10) @(posedge pclk);
        check(32'(out_led), 32'h08, "result held");
        repeat (30) @(posedge pclk);
        check(32'(out_led), 32'h5a, "hold expired");
        fork
            u_kto_panel.pulse_input(10);
            begin
                repeat (6) @(posedge pclk);
                check(32'(teach_req), 32'h1, "teach request on level");
            end
        join
        check(32'(teach_req), 32'h0, "teach request dropped");
        $display("teach role test done");
    endtask

    // reset, then the scenarios in order
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_reset();
        t_display();
        t_tolerance();
        t_discard();
        t_erase();
        t_options();
        t_gate();
        t_teach_role();
        complete_run();
    end
endmodule

// file: testbench/kto_panel.sv
// operator keypad and switching input model facing the menu controller
`timescale 1ns/1ps
module kto_panel import kto_pkg::*; #(
    parameter int TICK_CYC = 2
) (
    input wire logic pclk,
    output kto_keys_t keys,
    output logic sw,
    input wire logic [7:0] out_led
);
    logic [7:0] key_bits = 8'h00;
    logic sw_q = 1'b0;
    // released keys and the input fall back to the pull-down level
    assign keys = kto_keys_t'(key_bits);
    assign sw = sw_q;
    // hold one key for a number of ticks, then leave a quiet gap
    task automatic press(input int idx, input int ticks);
        key_bits[idx] <= 1'b1;
        repeat (ticks * TICK_CYC) @(posedge pclk);
        key_bits[idx] <= 1'b0;
        repeat (8 * TICK_CYC) @(posedge pclk);
    endtask
    // raise the switching input for a few cycles
    task automatic pulse_input(input int cycles);
        sw_q <= 1'b1;
        repeat (cycles) @(posedge pclk);
        sw_q <= 1'b0;
        repeat (cycles) @(posedge pclk);
    endtask
endmodule
